//--- bench/wss_datapath_test.sv
/*
 * self-checking bench for the wide simd datapath: corner and random
 * instructions checked against a shadow register file kept by the bench.
 * assumes the one-cycle execute, write port and shift-amount loads handed over.
 */
`timescale 1ns/1ps
module wss_datapath_test;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic issue_valid = 1'b0;
    logic [31:0] instr = 32'h0;
    logic gpr_wr_en = 1'b0;
    logic [4:0] gpr_wr_addr = 5'h0;
    logic [127:0] gpr_wr_data = 128'h0;
    logic sa_byte_load = 1'b0;
    logic sa_half_load = 1'b0;
    logic [3:0] sa_amount = 4'h0;
    logic done;
    logic illegal;
    logic [127:0] result;
    logic [4:0] result_dest;
    logic [6:0] sa_bits;
    logic [127:0] shadow [32];
    logic [127:0] last_res = 128'h0;
    logic [6:0] sa_exp = 7'h0;
    int mismatches = 0;
    int cmp_count = 0;
    // zero, widest byte, widest halfword, halfword low bits only, byte wins
    logic [5:0] s_tab [5] = '{6'h20, 6'h2f, 6'h17, 6'h1b, 6'h35};

    wss_datapath wss_datapath_i (.ref_clk(ref_clk), .rst_b(rst_b), .issue_valid(issue_valid),
        .instr(instr), .gpr_wr_en(gpr_wr_en), .gpr_wr_addr(gpr_wr_addr),
        .gpr_wr_data(gpr_wr_data), .sa_byte_load(sa_byte_load), .sa_half_load(sa_half_load),
        .sa_amount(sa_amount), .done(done), .illegal(illegal), .result(result),
        .result_dest(result_dest), .sa_bits(sa_bits));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // expectations
    // ------------------------------------------------------------
    // kinds 0..3 legal, 4 wrong group for the function, 5 wrong major opcode
    function automatic logic [31:0] enc(input int k, input logic [4:0] a, b, d);
        logic [4:0] fn [6] = '{wss_pkg::FN_SAT_UNSIGNED_WORD_SUBTRACT,
            wss_pkg::FN_WRAP_WORD_SUBTRACT, wss_pkg::FN_WIDE_EXCLUSIVE_OR,
            wss_pkg::FN_FUNNEL_SHIFT_RIGHT, wss_pkg::FN_SAT_UNSIGNED_WORD_SUBTRACT,
            wss_pkg::FN_WIDE_EXCLUSIVE_OR};
        logic [5:0] grp [6] = '{6'h28, 6'h08, 6'h09, 6'h28, 6'h08, 6'h09};
        return {(k == 5) ? 6'h1d : 6'h1c, a, b, d, fn[k], grp[k]};
    endfunction : enc

    function automatic logic [127:0] calc(input int k, input logic [127:0] a, b,
        input logic [6:0] sa);
        logic [255:0] cat;
        cat = {a, b} >> sa;
        calc = (k == 3) ? cat[127:0] : a ^ b;
        for (int i = 0; i < 4; i++) begin
            if (k < 2) begin
                calc[i*32 +: 32] = (k == 0 && a[i*32 +: 32] < b[i*32 +: 32]) ? 32'h0 :
                    a[i*32 +: 32] - b[i*32 +: 32];
            end
        end
    endfunction : calc

    // ------------------------------------------------------------
    // compare and drive tasks
    // ------------------------------------------------------------
    task automatic cmp_data(input logic [127:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_data

    task automatic cmp_flag(input logic [7:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_flag

    task automatic wr(input logic [4:0] addr, input logic [127:0] data);
        gpr_wr_en = 1'b1;
        gpr_wr_addr = addr;
        gpr_wr_data = data;
        if (addr != 5'h0) shadow[addr] = data;
        @(posedge ref_clk);
        #1 gpr_wr_en = 1'b0;
        @(posedge ref_clk);
        #1;
    endtask : wr

    task automatic sa_load(input logic by, hw, input logic [3:0] n);
        sa_byte_load = by;
        sa_half_load = hw;
        sa_amount = n;
        sa_exp = by ? {n, 3'h0} : (hw ? {n[2:0], 4'h0} : sa_exp);
        @(posedge ref_clk);
        #1;
        cmp_flag(sa_bits, sa_exp);
        sa_byte_load = 1'b0;
        sa_half_load = 1'b0;
        @(posedge ref_clk);
        #1;
    endtask : sa_load

    // leaves issue_valid high so the caller can issue back to back
    task automatic issue(input int k, input logic [4:0] a, b, d);
        instr = enc(k, a, b, d);
        issue_valid = 1'b1;
        if (k < 4) last_res = calc(k, shadow[a], shadow[b], sa_exp);
        @(posedge ref_clk);
        #1;
        cmp_flag(done, k < 4);
        cmp_flag(illegal, k > 3);
        cmp_data(result, last_res);
        if (k < 4) cmp_flag(result_dest, d);
        if (k < 4 && d != 5'h0) shadow[d] = last_res;
    endtask : issue

    task automatic results;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        int s;
        s = $urandom(32'h857533e5);
        shadow[0] = 128'h0;
        repeat (6) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        cmp_flag(done, 1'b0);
        cmp_data(result, 128'h0);
        cmp_flag(sa_bits, 7'h0);
        @(posedge ref_clk);
        #1;
        // lanes: below, equal, max minus zero, signed-looking borrow
        wr(5'h1, {32'h0, 32'h5, 32'hffffffff, 32'h7fffffff});
        wr(5'h2, {32'h1, 32'h5, 32'h0, 32'h80000000});
        for (int r = 0; r < 8; r++) begin
            if (r != 1 && r != 2) wr(r[4:0], {$urandom, $urandom, $urandom, $urandom});
        end
        foreach (s_tab[i]) begin
            sa_load(s_tab[i][5], s_tab[i][4], s_tab[i][3:0]);
            issue(3, 5'h1, 5'h2, 5'h5);
            issue_valid = 1'b0;
        end
        @(posedge ref_clk);
        #1;
        // a load in the issue cycle must not reach that funnel shift
        sa_byte_load = 1'b1;
        sa_amount = 4'h3;
        issue(3, 5'h1, 5'h2, 5'h5);
        sa_byte_load = 1'b0;
        sa_exp = 7'h18;
        cmp_flag(sa_bits, sa_exp);
        issue(0, 5'h1, 5'h2, 5'h3);
        issue(1, 5'h1, 5'h2, 5'h4);
        issue(2, 5'h1, 5'h2, 5'h0);
        issue(4, 5'h1, 5'h2, 5'h3);
        issue(5, 5'h1, 5'h2, 5'h3);
        issue(0, 5'h4, 5'h3, 5'h3);
        gpr_wr_en = 1'b1;
        gpr_wr_addr = 5'h6;
        gpr_wr_data = {4{$urandom}};
        issue(2, 5'h1, 5'h2, 5'h6);
        gpr_wr_en = 1'b0;
        issue(2, 5'h6, 5'h0, 5'h7);
        issue_valid = 1'b0;
        repeat (40) begin
            @(posedge ref_clk);
            #1;
            cmp_flag(done, 1'b0);
            cmp_flag(illegal, 1'b0);
            if ($urandom % 2) begin
                sa_load(1'($urandom % 2), 1'($urandom % 2), 4'($urandom % 16));
            end
            repeat (1 + $urandom % 4) begin
                issue($urandom % 6, 5'($urandom % 8), 5'($urandom % 8),
                    5'($urandom % 8));
            end
            issue_valid = 1'b0;
        end
        results();
    end

    initial begin
        #(50 * 5000);
        mismatches++;
        results();
    end
endmodule : wss_datapath_test

//--- src/wss_datapath.sv
/*
 * wide simd datapath: register file of 32 x 128 bits, shift-amount
 * register, decode of four multimedia operations and one-cycle execute.
 * assumes synchronous inputs on ref_clk and an outside party that loads
 * registers through the write port and the shift amount through its loads.
 */
`timescale 1ns/1ps
module wss_datapath (
    input wire logic ref_clk, // core clock, 20 MHz
    input wire logic rst_b, // synchronous reset, active low
    input wire logic issue_valid, // instruction presented this cycle
    input wire logic [31:0] instr, // instruction word
    input wire logic gpr_wr_en, // outside register write strobe
    input wire logic [4:0] gpr_wr_addr, // outside register write index
    input wire logic [127:0] gpr_wr_data, // outside register write data
    input wire logic sa_byte_load, // load shift amount in bytes
    input wire logic sa_half_load, // load shift amount in halfwords
    input wire logic [3:0] sa_amount, // byte or halfword count
    output logic done, // one-cycle pulse, result valid
    output logic illegal, // one-cycle pulse, not recognised
    output logic [127:0] result, // last result
    output logic [4:0] result_dest, // destination of last result
    output logic [6:0] sa_bits // shift amount in bits
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [127:0] gpr [0:wss_pkg::NUM_REGS-1];
    logic [wss_pkg::SA_BYTES_W-1:0] sa_bytes;
    wss_pkg::wss_op_e op_q;
    logic [127:0] a_q;
    logic [127:0] b_q;
    logic [6:0] sa_q;

    // register zero reads as zero so it can serve as a constant source
    function automatic logic [127:0] read_gpr(input logic [4:0] idx);
        read_gpr = (idx == 5'h0) ? wss_pkg::RESULT_RESET : gpr[idx];
    endfunction : read_gpr

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire [5:0] major = instr[wss_pkg::MAJOR_LSB +: 6];
    wire [4:0] func = instr[wss_pkg::FUNC_LSB +: 5];
    wire [5:0] group = instr[wss_pkg::GROUP_LSB +: 6];
    wire [4:0] src_a_idx = instr[wss_pkg::SRC_A_LSB +: 5];
    wire [4:0] src_b_idx = instr[wss_pkg::SRC_B_LSB +: 5];
    wire [4:0] dest_idx = instr[wss_pkg::DEST_LSB +: 5];
    wire is_major = (major == wss_pkg::MULTIMEDIA_MAJOR_OPCODE);
    wire dec_sat = is_major && (func == wss_pkg::FN_SAT_UNSIGNED_WORD_SUBTRACT)
        && (group == wss_pkg::MULTIMEDIA_GROUP_ONE);
    wire dec_wrap = is_major && (func == wss_pkg::FN_WRAP_WORD_SUBTRACT)
        && (group == wss_pkg::MULTIMEDIA_GROUP_ZERO);
    wire dec_xor = is_major && (func == wss_pkg::FN_WIDE_EXCLUSIVE_OR)
        && (group == wss_pkg::MULTIMEDIA_GROUP_TWO);
    wire dec_funnel = is_major && (func == wss_pkg::FN_FUNNEL_SHIFT_RIGHT)
        && (group == wss_pkg::MULTIMEDIA_GROUP_ONE);
    wire dec_any = dec_sat || dec_wrap || dec_xor || dec_funnel;
    wire exec = issue_valid && dec_any;
    wss_pkg::wss_op_e next_op;
    assign next_op = dec_sat ? wss_pkg::OP_SAT_SUB :
                     dec_wrap ? wss_pkg::OP_WRAP_SUB :
                     dec_xor ? wss_pkg::OP_XOR :
                     dec_funnel ? wss_pkg::OP_FUNNEL : wss_pkg::OP_NONE;

    // ------------------------------------------------------------
    // execute
    // ------------------------------------------------------------
    wire [127:0] opnd_a = read_gpr(src_a_idx);
    wire [127:0] opnd_b = read_gpr(src_b_idx);
    wire [6:0] sa_now = {sa_bytes, 3'b000};
    wire [127:0] sub_y;

    // separate lanes keep every borrow chain inside its own word
    genvar g;
    generate
        for (g = 0; g < wss_pkg::LANES; g++) begin : g_lane
            wss_lane_sub u_lane (
                .lane_a(opnd_a[g*32 +: 32]),
                .lane_b(opnd_b[g*32 +: 32]),
                .saturate(dec_sat),
                .lane_y(sub_y[g*32 +: 32])
            );
        end
    endgenerate

    wire [127:0] xor_y = opnd_a ^ opnd_b;
    wire [255:0] funnel_cat = {opnd_a, opnd_b};
    wire [255:0] funnel_shr = funnel_cat >> sa_now;
    wire [127:0] funnel_y = funnel_shr[127:0];
    wire [127:0] next_result = (dec_sat || dec_wrap) ? sub_y :
                               dec_xor ? xor_y : funnel_y;

    // ------------------------------------------------------------
    // shift-amount register
    // ------------------------------------------------------------
    // only whole bytes are stored, so a non-multiple of 8 cannot exist
    wire [3:0] next_sa = sa_byte_load ? sa_amount : {sa_amount[2:0], 1'b0};

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sa_bytes <= wss_pkg::SA_RESET;
        end else if (sa_byte_load || sa_half_load) begin
            sa_bytes <= next_sa;
        end
    end

    // ------------------------------------------------------------
    // register file write: execute wins over the outside port
    // ------------------------------------------------------------
    wire wr_exec = exec && (dest_idx != 5'h0);
    wire wr_ext = gpr_wr_en && !(wr_exec && gpr_wr_addr == dest_idx);

    always_ff @(posedge ref_clk) begin
        if (wr_exec) begin
            gpr[dest_idx] <= next_result;
        end
        if (wr_ext) begin
            gpr[gpr_wr_addr] <= gpr_wr_data;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            done <= 1'b0;
            illegal <= 1'b0;
            result <= wss_pkg::RESULT_RESET;
            result_dest <= wss_pkg::DEST_RESET;
            sa_bits <= wss_pkg::SA_BITS_RESET;
            op_q <= wss_pkg::OP_NONE;
            a_q <= wss_pkg::RESULT_RESET;
            b_q <= wss_pkg::RESULT_RESET;
            sa_q <= wss_pkg::SA_BITS_RESET;
        end else begin
            done <= exec;
            illegal <= issue_valid && !dec_any;
            sa_bits <= (sa_byte_load || sa_half_load) ? {next_sa, 3'b000} : sa_now;
            if (exec) begin
                result <= next_result;
                result_dest <= dest_idx;
                op_q <= next_op;
                a_q <= opnd_a;
                b_q <= opnd_b;
                sa_q <= sa_now;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // reference for the general shift, rebuilt from the captured operands
    wire [255:0] funnel_chk = {a_q, b_q} >> sa_q;

    a_decode_sat: assert property (issue_valid && dec_sat
        |=> done && op_q == wss_pkg::OP_SAT_SUB)
        else $error("sat subtract not decoded");
    a_sat_lanes: assert property (done && op_q == wss_pkg::OP_SAT_SUB
        && a_q[127:96] >= b_q[127:96]
        |-> result[127:96] == a_q[127:96] - b_q[127:96])
        else $error("sat lane difference wrong");
    a_sat_floor: assert property (done && op_q == wss_pkg::OP_SAT_SUB
        && a_q[31:0] < b_q[31:0] |-> result[31:0] == 32'h0)
        else $error("sat lane did not clamp");
    a_decode_wrap: assert property (issue_valid && dec_wrap
        |=> done && op_q == wss_pkg::OP_WRAP_SUB)
        else $error("wrap subtract not decoded");
    a_wrap_lane_diff: assert property (done && op_q == wss_pkg::OP_WRAP_SUB
        |-> result[63:32] == a_q[63:32] - b_q[63:32])
        else $error("wrap lane difference wrong");
    a_wrap_no_clamp: assert property (done && op_q == wss_pkg::OP_WRAP_SUB
        && a_q[95:64] < b_q[95:64]
        |-> result[95:64] == a_q[95:64] - b_q[95:64] && !illegal)
        else $error("wrap lane clamped or trapped");
    a_decode_xor: assert property (issue_valid && dec_xor
        |=> done && op_q == wss_pkg::OP_XOR)
        else $error("exclusive or not decoded");
    a_xor_full: assert property (done && op_q == wss_pkg::OP_XOR
        |-> result == (a_q ^ b_q))
        else $error("exclusive or result wrong");
    a_decode_funnel: assert property (issue_valid && dec_funnel
        |=> done && op_q == wss_pkg::OP_FUNNEL)
        else $error("funnel shift not decoded");
    a_funnel_zero: assert property (done && op_q == wss_pkg::OP_FUNNEL
        && sa_q == 7'h0 |-> result == b_q)
        else $error("zero shift did not copy second source");
    a_funnel_shift: assert property (done && op_q == wss_pkg::OP_FUNNEL
        |-> result == funnel_chk[127:0])
        else $error("funnel shift result wrong");
    a_sa_multiple: assert property ($past(sa_half_load) && !$past(sa_byte_load)
        |-> sa_bits[3:0] == 4'h0)
        else $error("shift amount not multiple of 16");
    a_sa_byte_load: assert property (sa_byte_load
        |=> sa_bits == {$past(sa_amount), 3'b000})
        else $error("byte shift amount not loaded");
    a_dest_field: assert property (exec
        |=> result_dest == $past(instr[15:11]))
        else $error("destination field not used");
    a_lane_isolate: assert property (done && op_q == wss_pkg::OP_WRAP_SUB
        && a_q[31:0] < b_q[31:0] |-> result[63:32] == a_q[63:32] - b_q[63:32])
        else $error("borrow crossed lane boundary");
    // the pulses must not outlive their issue cycle, nor fire without one
    a_illegal_quiet: assert property (issue_valid && !dec_any
        |=> illegal && !done && $stable(result))
        else $error("unrecognised word was executed");
    a_done_pulse: assert property (!issue_valid
        |=> !done && !illegal)
        else $error("completion pulse without an issue");

    c_sat_clamp: cover property (done && op_q == wss_pkg::OP_SAT_SUB && a_q[31:0] < b_q[31:0]);
    c_funnel_shift: cover property (done && op_q == wss_pkg::OP_FUNNEL && sa_q != 7'h0);
    c_xor_run: cover property (done && op_q == wss_pkg::OP_XOR);
    c_illegal: cover property (illegal);
    c_sa_half: cover property (sa_half_load && !sa_byte_load);

endmodule : wss_datapath

//--- src/wss_lane_sub.sv
/*
 * one 32-bit subtract lane with optional unsigned floor at zero.
 * assumes operands are stable for the cycle; purely combinational.
 */
`timescale 1ns/1ps
module wss_lane_sub (
    input wire logic [31:0] lane_a, // minuend
    input wire logic [31:0] lane_b, // subtrahend
    input wire logic saturate, // clamp negative results
    output logic [31:0] lane_y // lane result
);
    // borrow out of bit 31 only; nothing leaves this lane
    wire [32:0] diff = {1'b0, lane_a} - {1'b0, lane_b};
    wire borrow = diff[32];
    assign lane_y = (saturate && borrow) ? 32'h0 : diff[31:0];
endmodule : wss_lane_sub

//--- src/wss_pkg.sv
/*
 * constants, encodings and the operation type shared by the wide
 * subtract / exclusive-or / funnel-shift datapath.
 * assumes a single 20 MHz core clock and 128-bit general registers.
 */
// Function
// - decode saturating unsigned word subtract encoding
// - four unsigned 32-bit lanes, first minus second
// - negative lane difference clamps to zero, no exception
// - decode wrapping word subtract encoding
// - four independent 32-bit lane differences, low bits
// - wrapping subtract never traps, wraps modulo 2^32
// - decode wide exclusive or encoding
// - bitwise exclusive or over all 128 bits
// - decode quadword funnel shift right encoding
// - first:second shifted right, low quadword kept
// - shift amount only multiples of 8 or 16
// - register fields give first, second, destination
package wss_pkg;

    // ------------------------------------------------------------
    // widths and field positions
    // ------------------------------------------------------------
    localparam int DATA_W = 128;
    localparam int LANE_W = 32;
    localparam int LANES = 4;
    localparam int REG_IDX_W = 5;
    localparam int NUM_REGS = 32;
    localparam int MAJOR_LSB = 26;
    localparam int SRC_A_LSB = 21;
    localparam int SRC_B_LSB = 16;
    localparam int DEST_LSB = 11;
    localparam int FUNC_LSB = 6;
    localparam int GROUP_LSB = 0;
    localparam int SA_BYTES_W = 4;
    localparam int SA_BITS_W = 7;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [5:0] MULTIMEDIA_MAJOR_OPCODE = 6'h1c;
    localparam logic [5:0] MULTIMEDIA_GROUP_ZERO = 6'h08;
    localparam logic [5:0] MULTIMEDIA_GROUP_ONE = 6'h28;
    localparam logic [5:0] MULTIMEDIA_GROUP_TWO = 6'h09;
    localparam logic [4:0] FN_SAT_UNSIGNED_WORD_SUBTRACT = 5'h11;
    localparam logic [4:0] FN_WRAP_WORD_SUBTRACT = 5'h01;
    localparam logic [4:0] FN_WIDE_EXCLUSIVE_OR = 5'h13;
    localparam logic [4:0] FN_FUNNEL_SHIFT_RIGHT = 5'h1b;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [SA_BYTES_W-1:0] SA_RESET = 4'h0;
    localparam logic [DATA_W-1:0] RESULT_RESET = 128'h0;
    localparam logic [REG_IDX_W-1:0] DEST_RESET = 5'h0;
    localparam logic [SA_BITS_W-1:0] SA_BITS_RESET = 7'h0;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_SAT_SUB = 3'b001,
        OP_WRAP_SUB = 3'b010,
        OP_XOR = 3'b011,
        OP_FUNNEL = 3'b100
    } wss_op_e;

endpackage : wss_pkg
